// ---- dv/iat_irq_model.sv ----
`default_nettype none
// Stand-in for the two serial ports: each pulse on req_in becomes a request level
// held for three cycles, which is how long a port keeps its request up here.
module iat_irq_model
    import iat_pkg::*;
(
    // Clock
    input  wire logic       mclk_in,
    // Request pulses, bit 1 port one, bit 0 port two
    input  wire logic [1:0] req_in,
    // Request levels
    output iat_pkg::iat_irq_t irq_out
);
    import iat_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_reg [2:0];

    always_ff @(posedge mclk_in) begin
        hold_reg[0] <= req_in;
        hold_reg[1] <= hold_reg[0];
        hold_reg[2] <= hold_reg[1];
    end

    assign irq_out = iat_irq_t'(hold_reg[0] | hold_reg[1] | hold_reg[2]);
endmodule // iat_irq_model
`default_nettype wire

// ---- dv/tb.sv ----
`include "iat_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iat_pkg::*;
    localparam int MC = 10;
    logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic alarm_n, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp, req = 2'b00;
    iat_irq_t sirq;
    int errors = 0, checked = 0, cycles = 0, cnt, n, seed = 32'h0891f805;
    int m_mask, m_tmo, t0;

    always #12.5 mclk = ~mclk;

    iat_timer #(.MINUTE_CYCLES(MC)) i_iat_timer (.mclk_in(mclk), .nrst_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .serial_irq_in(sirq),
        .alarm_out_n_out(alarm_n), .irq_out(irq));
    iat_irq_model i_iat_irq_model (.mclk_in(mclk), .req_in(req), .irq_out(sirq));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // Counts cycles until the alarm falls, from the last load that the caller names.
    task automatic expect_expiry(input int mins, input int start);
        cnt = start;
        while (alarm_n !== 1'b0 && cnt < mins * MC + 8) begin
            @(posedge mclk);
            cnt++;
        end
        checked++;
        if (cnt < mins * MC - 3 || cnt > mins * MC + 6) begin
            errors++;
            $display("wrong value expiry cycles expected %0d seen %0d", mins * MC, cnt);
        end
    endtask

    task automatic pulse(input logic [1:0] r);
        @(posedge mclk);
        req <= r;
        @(posedge mclk);
        req <= 2'b00;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        m_mask = 0;
        m_tmo = 0;
        chk("alarm after reset", 32'h1, alarm_n);
        rd_reg(`IAT_ADDR_TIMEOUT);
        chk("timeout reset", m_tmo, rd);
        rd_reg(`IAT_ADDR_MASK);
        chk("mask reset", m_mask, rd);
        rd_reg(`IAT_ADDR_STATUS);
        chk("status reset", 32'h1, rd);
        rd_reg(8'h14);
        chk("unmapped resp", 32'h2, resp);
        $display("test reset done");

        repeat (4) begin
            m_mask = $random(seed) & 32'hFF;
            wr(`IAT_ADDR_MASK, m_mask);
            rd_reg(`IAT_ADDR_MASK);
            chk("mask readback", m_mask & 32'h0C, rd);
        end
        wr(`IAT_ADDR_STATUS, 32'h0);
        chk("status write resp", 32'h0, resp);
        wr(8'h14, 32'h0);
        chk("unmapped write resp", 32'h2, resp);
        rd_reg(`IAT_ADDR_STATUS);
        chk("status read only", 32'h1, rd);
        $display("test mask done");

        wr(`IAT_ADDR_MASK, 32'h0);
        n = 1 + ({$random(seed)} % 3);
        wr(`IAT_ADDR_TIMEOUT, n);
        t0 = cycles;
        rd_reg(`IAT_ADDR_STATUS);
        chk("status after start", 32'h1, rd);
        pulse(2'b11);
        expect_expiry(n, cycles - t0);
        rd_reg(`IAT_ADDR_STATUS);
        chk("status expired", 32'h0, rd);
        repeat (3 * MC) @(posedge mclk);
        chk("alarm stays low", 32'h0, alarm_n);
        chk("irq masked", 32'h0, irq);
        wr(`IAT_ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq while alarm", 32'h1, irq);
        rd_reg(`IAT_ADDR_IRQ_STAT);
        chk("irq status expiry", 32'h1, rd & 32'h1);
        wr(`IAT_ADDR_TIMEOUT, 32'h0);
        repeat (2) @(posedge mclk);
        chk("alarm released", 32'h1, alarm_n);
        wr(`IAT_ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0, irq);
        repeat (5 * MC) @(posedge mclk);
        chk("zero write stops", 32'h1, alarm_n);
        $display("test expiry done");

        for (int b = 2; b <= 3; b++) begin
            wr(`IAT_ADDR_MASK, 32'h1 << b);
            wr(`IAT_ADDR_TIMEOUT, 32'h2);
            repeat (6) begin
                repeat (2 * MC - 6) @(posedge mclk);
                pulse(b == 2 ? 2'b10 : 2'b01);
            end
            chk("alarm kept high", 32'h1, alarm_n);
            pulse(b == 2 ? 2'b01 : 2'b10);
            expect_expiry(2, 0);
            wr(`IAT_ADDR_TIMEOUT, 32'h0);
        end
        $display("test trigger done");
        stop_test();
    end
endmodule // tb
`default_nettype wire

// ---- rtl/iat_defs.svh ----
`ifndef IAT_DEFS_SVH
`define IAT_DEFS_SVH

// Register indices and their byte addresses; each register owns one aligned word.
`define IAT_IDX_TIMEOUT      2'h0
`define IAT_IDX_MASK         2'h1
`define IAT_IDX_STATUS       2'h2
`define IAT_IDX_IRQ_STAT     2'h3
`define IAT_IDX_IRQ_MASK     3'h4
`define IAT_ADDR_TIMEOUT     8'h00
`define IAT_ADDR_MASK        8'h04
`define IAT_ADDR_STATUS      8'h08
`define IAT_ADDR_IRQ_STAT    8'h0C
`define IAT_ADDR_IRQ_MASK    8'h10

// Field positions.
`define IAT_MSK_PORT_TWO     3
`define IAT_MSK_PORT_ONE     2
`define IAT_MSK_USED         8'h0C
`define IAT_ST_ALARM_BIT     0
`define IAT_EV_EXPIRE        0
`define IAT_EV_TRIGGER       1

// Reset values.
`define IAT_RST_TIMEOUT      8'h00
`define IAT_RST_MASK         8'h00
`define IAT_RST_STATUS       8'h01

// Timing: one minute of a 40 MHz clock.
`define IAT_CLK_HZ           40000000
`define IAT_MINUTE_S         60
`define IAT_MINUTE_CYCLES    (`IAT_CLK_HZ * `IAT_MINUTE_S)

`endif

// ---- rtl/iat_pkg.sv ----
`default_nettype none
package iat_pkg;
    typedef enum logic [1:0] {IAT_IDLE, IAT_COUNT, IAT_EXPIRED} iat_state_t;

    typedef struct packed {
        logic [7:0] timeout;
        logic [7:0] mask;
    } iat_cfg_t;

    typedef struct packed {
        logic port_one;
        logic port_two;
    } iat_irq_t;
endpackage
`default_nettype wire

// ---- rtl/iat_prescaler.sv ----
`include "iat_defs.svh"
`default_nettype none
module iat_prescaler #(
    parameter int unsigned MINUTE_CYCLES = `IAT_MINUTE_CYCLES
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic nrst_in,
    // Control
    input  wire logic restart_in,
    input  wire logic run_in,
    // Tick
    output logic      tick_out
);
    logic [31:0] cnt_reg;

    // The prescaler restarts on every load so a reload always buys a full minute.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || restart_in || !run_in) begin
            cnt_reg  <= 32'h0;
            tick_out <= 1'b0;
        end else if (cnt_reg == MINUTE_CYCLES - 1) begin
            cnt_reg  <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 32'h1;
            tick_out <= 1'b0;
        end
    end

    chk_tick_spacing: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        tick_out |=> !tick_out)
        else $error("Minute tick lasted more than one cycle.");
endmodule // iat_prescaler
`default_nettype wire

// ---- rtl/iat_timer.sv ----
`include "iat_defs.svh"
`default_nettype none
module iat_timer
    import iat_pkg::*;
#(
    parameter int unsigned MINUTE_CYCLES = `IAT_MINUTE_CYCLES
) (
    // Clock and reset
    input  wire logic           mclk_in,
    input  wire logic           nrst_in,
    // AXI4-Lite write address and data
    input  wire logic [7:0]     s_axi_awaddr_in,
    input  wire logic           s_axi_awvalid_in,
    output logic                s_axi_awready_out,
    input  wire logic [31:0]    s_axi_wdata_in,
    input  wire logic [3:0]     s_axi_wstrb_in,
    input  wire logic           s_axi_wvalid_in,
    output logic                s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]          s_axi_bresp_out,
    output logic                s_axi_bvalid_out,
    input  wire logic           s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [7:0]     s_axi_araddr_in,
    input  wire logic           s_axi_arvalid_in,
    output logic                s_axi_arready_out,
    output logic [31:0]         s_axi_rdata_out,
    output logic [1:0]          s_axi_rresp_out,
    output logic                s_axi_rvalid_out,
    input  wire logic           s_axi_rready_in,
    // Serial port interrupt requests
    input  wire iat_pkg::iat_irq_t serial_irq_in,
    // Alarm and interrupt
    output logic                alarm_out_n_out,
    output logic                irq_out
);
    import iat_pkg::*;

    iat_cfg_t   cfg_reg;
    iat_state_t state_reg;
    logic [7:0] count_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic       tick;
    logic       trigger;
    logic       do_write;
    logic       wr_timeout;
    logic       reload;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    // Write channel: address and data accepted in either order.
    assign do_write   = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
    assign wr_timeout = do_write && addr_hit(awaddr_reg, `IAT_ADDR_TIMEOUT) && wstrb_reg[0];

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            awaddr_reg        <= 8'h00;
            wdata_reg         <= 32'h0;
            wstrb_reg         <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= 2'h0;
        end else begin
            s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out && !s_axi_bvalid_out;
            s_axi_wready_out  <= !w_held_reg && !s_axi_wready_out && !s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_in;
                wstrb_reg  <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg      <= 1'b0;
                w_held_reg       <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (awaddr_reg <= `IAT_ADDR_IRQ_MASK && awaddr_reg[1:0] == 2'h0)
                                    ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Configuration registers; the timeout write doubles as start/stop command.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            cfg_reg.timeout <= `IAT_RST_TIMEOUT;
            cfg_reg.mask    <= `IAT_RST_MASK;
            irq_mask_reg    <= 2'h0;
        end else if (do_write && wstrb_reg[0]) begin
            if (addr_hit(awaddr_reg, `IAT_ADDR_TIMEOUT))
                cfg_reg.timeout <= wdata_reg[7:0];
            if (addr_hit(awaddr_reg, `IAT_ADDR_MASK))
                cfg_reg.mask <= wdata_reg[7:0] & `IAT_MSK_USED;
            if (addr_hit(awaddr_reg, `IAT_ADDR_IRQ_MASK))
                irq_mask_reg <= wdata_reg[1:0];
        end
    end

    // Only enabled serial requests count as activity.
    assign trigger = (cfg_reg.mask[`IAT_MSK_PORT_TWO] && serial_irq_in.port_two)
                  || (cfg_reg.mask[`IAT_MSK_PORT_ONE] && serial_irq_in.port_one);
    assign reload  = wr_timeout || (state_reg == IAT_COUNT && trigger);

    iat_prescaler #(
        .MINUTE_CYCLES (MINUTE_CYCLES)
    ) u_prescaler (
        .mclk_in    (mclk_in),
        .nrst_in    (nrst_in),
        .restart_in (reload),
        .run_in     (state_reg == IAT_COUNT),
        .tick_out   (tick)
    );

    // Countdown state machine. Triggers after expiry are ignored until software rewrites.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_reg       <= IAT_IDLE;
            count_reg       <= 8'h00;
            alarm_out_n_out <= 1'b1;
        end else if (wr_timeout) begin
            count_reg       <= wdata_reg[7:0];
            alarm_out_n_out <= 1'b1;
            state_reg       <= (wdata_reg[7:0] != 8'h00) ? IAT_COUNT : IAT_IDLE;
        end else begin
            unique case (state_reg)
                IAT_IDLE: begin
                end
                IAT_COUNT: begin
                    if (trigger) begin
                        count_reg <= cfg_reg.timeout;
                    end else if (tick) begin
                        if (count_reg == 8'h01) begin
                            count_reg       <= 8'h00;
                            state_reg       <= IAT_EXPIRED;
                            alarm_out_n_out <= 1'b0;
                        end else begin
                            count_reg <= count_reg - 8'h01;
                        end
                    end
                end
                IAT_EXPIRED: begin
                end
                default: state_reg <= IAT_IDLE;
            endcase
        end
    end

    // Sticky events: set wins over a same-cycle write-one-to-clear.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            irq_stat_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `IAT_EV_EXPIRE && state_reg == IAT_COUNT && tick && !trigger
                     && count_reg == 8'h01 && !wr_timeout)
                    || (i == `IAT_EV_TRIGGER && reload && !wr_timeout))
                    irq_stat_reg[i] <= 1'b1;
                else if (do_write && wstrb_reg[0] && addr_hit(awaddr_reg, `IAT_ADDR_IRQ_STAT)
                         && wdata_reg[i])
                    irq_stat_reg[i] <= 1'b0;
            end
        end
    end

    // Alarm interrupt stays up as long as the alarm is active.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(irq_stat_reg & irq_mask_reg) || (irq_mask_reg[`IAT_EV_EXPIRE]
                       && state_reg == IAT_EXPIRED && !wr_timeout);
    end

    // Read channel.
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0;
            s_axi_rresp_out   <= 2'h0;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out  <= 1'b1;
                s_axi_rresp_out   <= 2'h0;
                s_axi_rdata_out   <= 32'h0;
                if (addr_hit(s_axi_araddr_in, `IAT_ADDR_TIMEOUT))
                    s_axi_rdata_out[7:0] <= cfg_reg.timeout;
                else if (addr_hit(s_axi_araddr_in, `IAT_ADDR_MASK))
                    s_axi_rdata_out[7:0] <= cfg_reg.mask;
                else if (addr_hit(s_axi_araddr_in, `IAT_ADDR_STATUS))
                    s_axi_rdata_out[0] <= alarm_out_n_out;
                else if (addr_hit(s_axi_araddr_in, `IAT_ADDR_IRQ_STAT))
                    s_axi_rdata_out[1:0] <= irq_stat_reg;
                else if (addr_hit(s_axi_araddr_in, `IAT_ADDR_IRQ_MASK))
                    s_axi_rdata_out[1:0] <= irq_mask_reg;
                else
                    s_axi_rresp_out <= 2'h2;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    chk_trig_reload: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state_reg == IAT_COUNT && trigger && !wr_timeout |=> count_reg == $past(cfg_reg.timeout))
        else $error("Trigger did not reload the counter.");
    chk_masked_ignored: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state_reg == IAT_COUNT && !trigger && !tick && !wr_timeout |=> $stable(count_reg))
        else $error("Counter moved without a tick or trigger.");
    chk_port_two: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        cfg_reg.mask[3] && serial_irq_in.port_two |-> trigger)
        else $error("Port two request not seen as trigger.");
    chk_port_one: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        cfg_reg.mask[2] && serial_irq_in.port_one |-> trigger)
        else $error("Port one request not seen as trigger.");
    chk_port_masked: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !cfg_reg.mask[2] && !cfg_reg.mask[3] |-> !trigger)
        else $error("Masked request acted as trigger.");
    chk_expire_alarm: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state_reg == IAT_COUNT && tick && !trigger && count_reg == 8'h01 && !wr_timeout
        |=> !alarm_out_n_out && state_reg == IAT_EXPIRED)
        else $error("Expiry did not assert the alarm.");
    chk_alarm_state: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !alarm_out_n_out |-> state_reg == IAT_EXPIRED)
        else $error("Alarm active outside the expired state.");
    chk_write_release: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        wr_timeout |=> alarm_out_n_out && (state_reg == IAT_IDLE) == ($past(wdata_reg[7:0]) == 8'h00))
        else $error("Timeout write did not release or start correctly.");
    chk_decrement: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state_reg == IAT_COUNT && tick && !trigger && !wr_timeout && count_reg > 8'h01
        |=> count_reg == $past(count_reg) - 8'h01)
        else $error("Counter did not decrement by one on the tick.");
    chk_irq_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        irq_mask_reg[0] && state_reg == IAT_EXPIRED ##1 state_reg == IAT_EXPIRED |-> irq_out)
        else $error("Interrupt dropped while alarm active.");
    chk_status_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h08
        |=> s_axi_rdata_out == {31'h0, $past(alarm_out_n_out)})
        else $error("Status read does not mirror alarm.");
    chk_reset_status: assert property (@(posedge mclk_in)
        !nrst_in |=> alarm_out_n_out && state_reg == IAT_IDLE)
        else $error("Reset did not clear the alarm.");

    cov_expire: cover property (@(posedge mclk_in) disable iff (!nrst_in) $fell(alarm_out_n_out));
    cov_trigger: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        state_reg == IAT_COUNT && trigger);
    cov_stop: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        wr_timeout && wdata_reg[7:0] == 8'h00);
endmodule // iat_timer
`default_nettype wire
